/* rtl/lfo_ctrl.sv */
// Low-frequency oscillator control: registers, run gating, start-up and interrupts.
`timescale 1ns/1ps
`include "lfo_map.svh"
module lfo_ctrl #(
	parameter int          NUM_REQ       = 4,
	parameter int unsigned STARTUP_SHIFT = 0
) (
	// Clock and reset.
	input  wire logic                   clock_in,
	input  wire logic                   rst_in,
	// APB slave.
	input  wire logic                   psel_in,
	input  wire logic                   penable_in,
	input  wire logic                   pwrite_in,
	input  wire logic [`LFO_ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]            pwdata_in,
	output logic                        pready_out,
	output logic      [31:0]            prdata_out,
	output logic                        pslverr_out,
	// System state and peripheral clock requests.
	input  wire logic                   standby_in,
	input  wire logic [NUM_REQ-1:0]     ext_clk_req_in,
	input  wire logic [NUM_REQ-1:0]     int_clk_req_in,
	// Oscillator clocks seen as asynchronous levels.
	input  wire logic                   ulp_clk_in,
	input  wire logic                   slow_osc_input_pad_in,
	input  wire logic                   int_osc_clk_in,
	// Multipurpose crystal oscillator controls.
	output logic                        mp_osc_run_out,
	output logic                        mp_crystal_pad_mode_out,
	output logic                        mp_osc_output_pad_oe_out,
	// External 32kHz crystal oscillator controls.
	output logic                        ext_osc_run_out,
	output logic                        ext_crystal_pad_mode_out,
	output logic                        slow_osc_output_pad_oe_out,
	output logic                        ext_auto_amplitude_out,
	output logic                        ext_clk32k_out_en_out,
	// Internal 32kHz oscillator controls.
	output logic                        int_osc_run_out,
	output logic                        int_clk32k_out_en_out,
	output logic      [6:0]             int_calibration_value_out,
	// Interrupt.
	output logic                        irq_out
);
	////////////////////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic [31:0] mp_ctrl_q;
	logic [31:0] ext_ctrl_q;
	logic [31:0] int_ctrl_q;
	logic [2:0]  irq_status_q;
	logic [2:0]  irq_enable_q;
	logic [2:0]  irq_status_d;
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        wr_en;
	logic        access;
	logic        mapped;
	logic [31:0] rd_data;
	logic [2:0]  rise;
	logic        ext_run;
	logic        int_run;
	logic        ext_ready_q;
	logic        int_ready_q;
	logic        ext_ready_rise;
	logic        int_ready_rise;
	logic [2:0]  status_now;

	lfo_start_if ext_st ();
	lfo_start_if int_st ();

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Run condition shared by both slow oscillators.
	function automatic logic osc_should_run(input logic [31:0] ctrl, input logic req_any,
			input logic standby);
		logic en;
		logic gated_ok;
		logic stdby_ok;
		en       = ctrl[`LFO_BIT_ENABLE];
		gated_ok = !ctrl[`LFO_BIT_REQ_GATED] || req_any;
		stdby_ok = !standby || ctrl[`LFO_BIT_RUN_STDBY];
		return en && gated_ok && stdby_ok;
	endfunction

	// Merge written bits into a register under its writable mask.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
			input logic [31:0] mask);
		return (old & ~mask) | (wdata & mask);
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////////
	// APB decode.

	// A transfer completes on the edge where pready is seen high in the access phase.
	assign access = psel_in && penable_in && pready_q;
	assign wr_en  = access && pwrite_in;

	// Address decode for mapped words.
	always_comb begin
		mapped  = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr_in)
			`LFO_OFF_STATUS:     rd_data = {29'h0000_0000, status_now};
			`LFO_OFF_MP_CTRL:    rd_data = mp_ctrl_q;
			`LFO_OFF_EXT_CTRL:   rd_data = ext_ctrl_q;
			`LFO_OFF_INT_CTRL:   rd_data = int_ctrl_q;
			`LFO_OFF_IRQ_STATUS: rd_data = {29'h0000_0000, irq_status_q};
			`LFO_OFF_IRQ_CLEAR:  rd_data = 32'h0000_0000;
			`LFO_OFF_IRQ_ENABLE: rd_data = {29'h0000_0000, irq_enable_q};
			default:             mapped  = 1'b0;
		endcase
	end

	// Ready rises one cycle into the access phase; data and error come with it.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel_in && penable_in && !pready_q;
			prdata_q  <= (psel_in && penable_in && !pready_q && !pwrite_in) ? rd_data : 32'h0000_0000;
			pslverr_q <= psel_in && penable_in && !pready_q && !mapped;
		end
	end

	assign pready_out  = pready_q;
	assign prdata_out  = prdata_q;
	assign pslverr_out = pslverr_q;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	// multipurpose oscillator pad mode and enable.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mp_ctrl_q <= `LFO_RST_MP_CTRL;
		end else if (wr_en && paddr_in == `LFO_OFF_MP_CTRL) begin
			mp_ctrl_q <= merge(mp_ctrl_q, pwdata_in, `LFO_MP_CTRL_MASK);
		end
	end

	// writes ignored once locked, until reset.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ext_ctrl_q <= `LFO_RST_EXT_CTRL;
		end else if (wr_en && paddr_in == `LFO_OFF_EXT_CTRL && !ext_ctrl_q[`LFO_BIT_LOCK]) begin
			ext_ctrl_q <= merge(ext_ctrl_q, pwdata_in, `LFO_EXT_CTRL_MASK);
		end
	end

	// calibration is software-written; lock freezes it too.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			int_ctrl_q <= `LFO_RST_INT_CTRL;
		end else if (wr_en && paddr_in == `LFO_OFF_INT_CTRL && !int_ctrl_q[`LFO_BIT_LOCK]) begin
			int_ctrl_q <= merge(int_ctrl_q, pwdata_in, `LFO_INT_CTRL_MASK);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Oscillator clock synchronisation.

	// Reference, crystal and internal oscillator clocks become tick pulses.
	lfo_sync #(
		.WIDTH (3)
	) u_sync (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.async_in ({int_osc_clk_in, slow_osc_input_pad_in, ulp_clk_in}),
		.rise_out (rise)
	);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Run gating.

	assign ext_run = osc_should_run(ext_ctrl_q, |ext_clk_req_in, standby_in);

	// internal oscillator uses the same gating.
	assign int_run = osc_should_run(int_ctrl_q, |int_clk_req_in, standby_in);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Start-up sequencers.

	// External crystal: reference ticks, then crystal ticks.
	assign ext_st.run        = ext_run;
	assign ext_st.code       = ext_ctrl_q[`LFO_BIT_STARTUP_LO +: 3];
	assign ext_st.count_tick = rise[0];
	assign ext_st.osc_tick   = rise[1];

	lfo_startup #(
		.SYNC_CYCLES (`LFO_EXT_SYNC_CYCLES),
		.INT_TABLE   (1'b0),
		.SHIFT       (STARTUP_SHIFT)
	) u_ext_startup (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.st       (ext_st.unit)
	);

	// Internal oscillator: reference ticks, then its own ticks.
	assign int_st.run        = int_run;
	assign int_st.code       = int_ctrl_q[`LFO_BIT_STARTUP_LO +: 3];
	assign int_st.count_tick = rise[0];
	assign int_st.osc_tick   = rise[2];

	lfo_startup #(
		.SYNC_CYCLES (`LFO_INT_SYNC_CYCLES),
		.INT_TABLE   (1'b1),
		.SHIFT       (STARTUP_SHIFT)
	) u_int_startup (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.st       (int_st.unit)
	);

	// Ready flags registered for the status word and edge detection.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ext_ready_q <= 1'b0;
			int_ready_q <= 1'b0;
		end else begin
			ext_ready_q <= ext_st.ready;
			int_ready_q <= int_st.ready;
		end
	end

	assign ext_ready_rise = ext_st.ready && !ext_ready_q;
	assign int_ready_rise = int_st.ready && !int_ready_q;
	assign status_now     = {int_ready_q, ext_ready_q, 1'b0};

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Interrupts.

	// Sticky ready events; a new event wins over a clear in the same cycle.
	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_en && paddr_in == `LFO_OFF_IRQ_CLEAR) begin
			irq_status_d = irq_status_d & ~pwdata_in[2:0];
		end
		irq_status_d[`LFO_BIT_EXT_READY] = irq_status_d[`LFO_BIT_EXT_READY] || ext_ready_rise;
		irq_status_d[`LFO_BIT_INT_READY] = irq_status_d[`LFO_BIT_INT_READY] || int_ready_rise;
		irq_status_d[0] = 1'b0;
	end

	// Status and enable registers.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			irq_status_q <= 3'h0;
			irq_enable_q <= 3'h0;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_en && paddr_in == `LFO_OFF_IRQ_ENABLE) begin
				irq_enable_q <= pwdata_in[2:0] & 3'h6;
			end
		end
	end

	// Level interrupt while any enabled event is pending.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status_q & irq_enable_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Registered oscillator and pad controls.

	// Multipurpose oscillator pad connection and enable.
	// output pad driven only in crystal mode while enabled.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			mp_osc_run_out           <= 1'b0;
			mp_crystal_pad_mode_out  <= 1'b0;
			mp_osc_output_pad_oe_out <= 1'b0;
		end else begin
			mp_osc_run_out           <= mp_ctrl_q[`LFO_BIT_ENABLE];
			mp_crystal_pad_mode_out  <= mp_ctrl_q[`LFO_BIT_PAD_MODE];
			mp_osc_output_pad_oe_out <= mp_ctrl_q[`LFO_BIT_PAD_MODE] && mp_ctrl_q[`LFO_BIT_ENABLE];
		end
	end

	// External crystal oscillator controls.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ext_osc_run_out            <= 1'b0;
			ext_crystal_pad_mode_out   <= 1'b0;
			slow_osc_output_pad_oe_out <= 1'b0;
			ext_auto_amplitude_out     <= 1'b0;
			ext_clk32k_out_en_out      <= 1'b0;
		end else begin
			ext_osc_run_out            <= ext_run;
			// pad mode; output pad freed in external-clock mode.
			ext_crystal_pad_mode_out   <= ext_ctrl_q[`LFO_BIT_PAD_MODE];
			slow_osc_output_pad_oe_out <= ext_ctrl_q[`LFO_BIT_PAD_MODE] && ext_run;
			ext_auto_amplitude_out     <= ext_ctrl_q[`LFO_BIT_AUTO_AMP];
			ext_clk32k_out_en_out      <= ext_ctrl_q[`LFO_BIT_EXT_OUT_EN] && ext_run;
		end
	end

	// Internal oscillator controls.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			int_osc_run_out           <= 1'b0;
			int_clk32k_out_en_out     <= 1'b0;
			int_calibration_value_out <= 7'h3f;
		end else begin
			int_osc_run_out           <= int_run;
			int_clk32k_out_en_out     <= int_ctrl_q[`LFO_BIT_INT_OUT_EN] && int_run;
			int_calibration_value_out <= int_ctrl_q[`LFO_BIT_CALIBRATION_VALUE_LO +: 7];
		end
	end

endmodule

/* rtl/lfo_map.svh */
// Register offsets, field positions, reset values and start-up counts of the oscillator control.
`ifndef LFO_MAP_SVH
`define LFO_MAP_SVH

`define LFO_ADDR_W 8
`define LFO_OFF_STATUS 8'h0c
`define LFO_OFF_MP_CTRL 8'h10
`define LFO_OFF_EXT_CTRL 8'h14
`define LFO_OFF_INT_CTRL 8'h18
`define LFO_OFF_IRQ_STATUS 8'h24
`define LFO_OFF_IRQ_CLEAR 8'h28
`define LFO_OFF_IRQ_ENABLE 8'h2c

`define LFO_BIT_ENABLE 1
`define LFO_BIT_PAD_MODE 2
`define LFO_BIT_EXT_OUT_EN 3
`define LFO_BIT_INT_OUT_EN 2
`define LFO_BIT_AUTO_AMP 5
`define LFO_BIT_RUN_STDBY 6
`define LFO_BIT_REQ_GATED 7
`define LFO_BIT_STARTUP_LO 8
`define LFO_BIT_LOCK 12
`define LFO_BIT_CALIBRATION_VALUE_LO 16

`define LFO_BIT_EXT_READY 1
`define LFO_BIT_INT_READY 2

`define LFO_RST_MP_CTRL 32'h0000_0000
`define LFO_RST_EXT_CTRL 32'h0000_0080
`define LFO_RST_INT_CTRL 32'h003f_0080
`define LFO_EXT_CTRL_MASK 32'h0000_17ee
`define LFO_INT_CTRL_MASK 32'h007f_17c6
`define LFO_MP_CTRL_MASK 32'h0000_0006

`define LFO_EXT_SYNC_CYCLES 3
`define LFO_INT_SYNC_CYCLES 2
`define LFO_EXT_SU_0 18'h00001
`define LFO_EXT_SU_1 18'h00020
`define LFO_EXT_SU_2 18'h00800
`define LFO_EXT_SU_3 18'h01000
`define LFO_EXT_SU_4 18'h04000
`define LFO_EXT_SU_5 18'h08000
`define LFO_EXT_SU_6 18'h10000
`define LFO_EXT_SU_7 18'h20000

`endif

/* rtl/lfo_pkg.sv */
// Types shared by the oscillator control modules.
package lfo_pkg;

	// One-hot start-up sequencer states.
	typedef enum logic [3:0] {
		LFO_OFF   = 4'b0001,
		LFO_COUNT = 4'b0010,
		LFO_SYNC  = 4'b0100,
		LFO_READY = 4'b1000
	} lfo_state_type;

	typedef logic [17:0] lfo_count_type;

endpackage

/* rtl/lfo_start_if.sv */
// Interface between the control top and one oscillator start-up sequencer.
`timescale 1ns/1ps
interface lfo_start_if;
	logic       run;
	logic [2:0] code;
	logic       count_tick;
	logic       osc_tick;
	logic       ready;

	modport ctrl (output run, output code, output count_tick, output osc_tick, input ready);
	modport unit (input run, input code, input count_tick, input osc_tick, output ready);
endinterface

/* rtl/lfo_sync.sv */
// Two-stage synchronisers with rising-edge pulses for oscillator clock inputs.
`timescale 1ns/1ps
module lfo_sync #(
	parameter int WIDTH = 3
) (
	// Clock and reset.
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	// Asynchronous levels and their synchronised rising edges.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] rise_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] last_q;

	// The first stage feeds only the second; edges are taken after it.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// One-cycle pulse per rising edge of each input.
	assign rise_out = sync_q & ~last_q;
endmodule

/* rtl/lfo_startup.sv */
// Start-up sequencer: counts slow-reference ticks, then oscillator ticks, then flags ready.
`timescale 1ns/1ps
`include "lfo_map.svh"
module lfo_startup #(
	parameter int          SYNC_CYCLES = 3,
	parameter bit          INT_TABLE   = 1'b0,
	parameter int unsigned SHIFT       = 0
) (
	// Clock and reset.
	input  wire logic clock_in,
	input  wire logic rst_in,
	// Control side.
	lfo_start_if.unit st
);
	lfo_pkg::lfo_state_type state_q;
	lfo_pkg::lfo_count_type cnt_q;

	// Reference ticks for a start-up code, shortened by SHIFT but never below one.
	function automatic lfo_pkg::lfo_count_type su_cycles(input logic [2:0] code);
		lfo_pkg::lfo_count_type n;
		n = 18'h00001;
		if (INT_TABLE) begin
			n = lfo_pkg::lfo_count_type'(18'h00001 << code);
		end else begin
			case (code)
				3'h0: n = `LFO_EXT_SU_0;
				3'h1: n = `LFO_EXT_SU_1;
				3'h2: n = `LFO_EXT_SU_2;
				3'h3: n = `LFO_EXT_SU_3;
				3'h4: n = `LFO_EXT_SU_4;
				3'h5: n = `LFO_EXT_SU_5;
				3'h6: n = `LFO_EXT_SU_6;
				default: n = `LFO_EXT_SU_7;
			endcase
		end
		n = n >> SHIFT;
		if (n == 18'h00000) begin
			n = 18'h00001;
		end
		return n;
	endfunction

	// start-up counter: reference ticks, then oscillator ticks.
	// stopping drops ready and restarts the count.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_q <= lfo_pkg::LFO_OFF;
			cnt_q   <= 18'h00000;
		end else if (!st.run) begin
			state_q <= lfo_pkg::LFO_OFF;
			cnt_q   <= 18'h00000;
		end else begin
			case (state_q)
				lfo_pkg::LFO_OFF: begin
					state_q <= lfo_pkg::LFO_COUNT;
					cnt_q   <= su_cycles(st.code);
				end
				lfo_pkg::LFO_COUNT: begin
					if (st.count_tick) begin
						if (cnt_q == 18'h00001) begin
							state_q <= lfo_pkg::LFO_SYNC;
							cnt_q   <= lfo_pkg::lfo_count_type'(SYNC_CYCLES);
						end else begin
							cnt_q <= cnt_q - 18'h00001;
						end
					end
				end
				// synchronisation ticks of the oscillator itself.
				lfo_pkg::LFO_SYNC: begin
					if (st.osc_tick) begin
						if (cnt_q == 18'h00001) begin
							state_q <= lfo_pkg::LFO_READY;
						end else begin
							cnt_q <= cnt_q - 18'h00001;
						end
					end
				end
				lfo_pkg::LFO_READY: begin
					state_q <= lfo_pkg::LFO_READY;
				end
				default: begin
					state_q <= lfo_pkg::LFO_OFF;
				end
			endcase
		end
	end

	assign st.ready = (state_q == lfo_pkg::LFO_READY);
endmodule

/* test/lfo_xtal_model.sv */
// Behavioural crystal or clock source on the slow oscillator pads.
`timescale 1ns/1ps
module lfo_xtal_model #(
	parameter int HALF_NS = 450
) (
	// Run control from the block.
	input  wire logic run_in,
	// Pad level and rising edges since start.
	output logic      pad_out,
	output int        edges_out
);
	initial begin
		pad_out = 1'h0;
		edges_out = 0;
		forever begin
			#(HALF_NS);
			if (run_in) begin
				pad_out = !pad_out;
				edges_out = edges_out + 32'(pad_out);
			end else begin
				pad_out = 1'h0;
				edges_out = 0;
			end
		end
	end
endmodule

/* test/lfo_ctrl_asserts.sv */
// Port-level checks of the oscillator control.
`timescale 1ns/1ps
`include "lfo_map.svh"
module lfo_ctrl_asserts #(
	parameter int NUM_REQ = 4
) (
	// Clock, reset and bus.
	input wire logic                   clock_in,
	input wire logic                   rst_in,
	input wire logic                   psel_in,
	input wire logic                   penable_in,
	input wire logic                   pwrite_in,
	input wire logic [`LFO_ADDR_W-1:0] paddr_in,
	input wire logic [31:0]            pwdata_in,
	input wire logic                   pready_out,
	input wire logic [31:0]            prdata_out,
	input wire logic                   pslverr_out,
	// Run causes and oscillator controls.
	input wire logic                   standby_in,
	input wire logic [NUM_REQ-1:0]     ext_clk_req_in,
	input wire logic [NUM_REQ-1:0]     int_clk_req_in,
	input wire logic                   mp_osc_run_out,
	input wire logic                   mp_crystal_pad_mode_out,
	input wire logic                   mp_osc_output_pad_oe_out,
	input wire logic                   ext_osc_run_out,
	input wire logic                   ext_crystal_pad_mode_out,
	input wire logic                   slow_osc_output_pad_oe_out,
	input wire logic                   ext_clk32k_out_en_out,
	input wire logic                   int_osc_run_out,
	input wire logic                   int_clk32k_out_en_out
);
	logic [31:0] ext_q;
	logic [31:0] int_q;
	logic        wr_hit;
	logic        ext_go;
	logic        int_go;

	// Completed writes and the run conditions built from the shadows.
	assign wr_hit = psel_in && penable_in && pready_out && pwrite_in;
	assign ext_go = ext_q[1] && (!ext_q[7] || |ext_clk_req_in) && (!standby_in || ext_q[6]);
	assign int_go = int_q[1] && (!int_q[7] || |int_clk_req_in) && (!standby_in || int_q[6]);

	// Shadow copies of both control words; a set lock bit stops writes.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ext_q <= `LFO_RST_EXT_CTRL;
			int_q <= `LFO_RST_INT_CTRL;
		end else if (wr_hit && paddr_in == `LFO_OFF_EXT_CTRL && !ext_q[12]) begin
			ext_q <= pwdata_in & `LFO_EXT_CTRL_MASK;
		end else if (wr_hit && paddr_in == `LFO_OFF_INT_CTRL && !int_q[12]) begin
			int_q <= pwdata_in & `LFO_INT_CTRL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("ready not one cycle into access");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out)
		else $error("ready stood two cycles");
	a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside answer");
	a_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_mp_pad_oe: assert property (
		mp_osc_output_pad_oe_out == (mp_crystal_pad_mode_out && mp_osc_run_out))
		else $error("mp output pad drive wrong");
	a_ext_pad_oe: assert property (
		slow_osc_output_pad_oe_out == (ext_crystal_pad_mode_out && ext_osc_run_out))
		else $error("slow output pad drive wrong");
	a_ext_out_gate: assert property (ext_clk32k_out_en_out |-> ext_osc_run_out)
		else $error("ext output on while stopped");
	a_int_out_gate: assert property (int_clk32k_out_en_out |-> int_osc_run_out)
		else $error("int output on while stopped");
	a_ext_run_cond: assert property (ext_osc_run_out == $past(ext_go))
		else $error("ext run differs from its cause");
	a_int_run_cond: assert property (int_osc_run_out == $past(int_go))
		else $error("int run differs from its cause");
endmodule

bind lfo_ctrl lfo_ctrl_asserts #(.NUM_REQ(NUM_REQ)) i_chk (
	.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
	.standby_in(standby_in), .ext_clk_req_in(ext_clk_req_in),
	.int_clk_req_in(int_clk_req_in), .mp_osc_run_out(mp_osc_run_out),
	.mp_crystal_pad_mode_out(mp_crystal_pad_mode_out),
	.mp_osc_output_pad_oe_out(mp_osc_output_pad_oe_out), .ext_osc_run_out(ext_osc_run_out),
	.ext_crystal_pad_mode_out(ext_crystal_pad_mode_out),
	.slow_osc_output_pad_oe_out(slow_osc_output_pad_oe_out),
	.ext_clk32k_out_en_out(ext_clk32k_out_en_out), .int_osc_run_out(int_osc_run_out),
	.int_clk32k_out_en_out(int_clk32k_out_en_out));

/* test/lfo_ctrl_tb.sv */
// Register-level testbench of the oscillator control.
`timescale 1ns/1ps
`include "lfo_map.svh"
module lfo_ctrl_tb;
	localparam int         SHIFT = 10;
	localparam logic [7:0] EXT   = `LFO_OFF_EXT_CTRL;
	localparam logic [7:0] INT   = `LFO_OFF_INT_CTRL;
	localparam logic [7:0] STAT  = `LFO_OFF_STATUS;
	localparam logic [7:0] IEN   = `LFO_OFF_IRQ_ENABLE;
	logic        clock_in, rst_in, psel, penable, pwrite, standby, ulp_clk, int_clk, pad;
	logic        pready, pslverr, mp_run, mp_pad, mp_oe, ext_run, ext_pad, ext_oe, err;
	logic        ext_aa, ext_oen, int_run, int_oen, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  cal;
	logic [3:0]  ext_req, int_req;
	int          failures, num_checks, cycles, ulp_edges, pad_edges;

	lfo_ctrl #(.NUM_REQ(4), .STARTUP_SHIFT(SHIFT)) i_dut (
		.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .standby_in(standby),
		.ext_clk_req_in(ext_req), .int_clk_req_in(int_req), .ulp_clk_in(ulp_clk),
		.slow_osc_input_pad_in(pad), .int_osc_clk_in(int_clk), .mp_osc_run_out(mp_run),
		.mp_crystal_pad_mode_out(mp_pad), .mp_osc_output_pad_oe_out(mp_oe),
		.ext_osc_run_out(ext_run), .ext_crystal_pad_mode_out(ext_pad),
		.slow_osc_output_pad_oe_out(ext_oe), .ext_auto_amplitude_out(ext_aa),
		.ext_clk32k_out_en_out(ext_oen), .int_osc_run_out(int_run),
		.int_clk32k_out_en_out(int_oen), .int_calibration_value_out(cal), .irq_out(irq));

	lfo_xtal_model i_xtal (.run_in(ext_run), .pad_out(pad), .edges_out(pad_edges));

	// System clock and the two unrelated oscillator clocks.
	initial begin
		clock_in = 1'h0;
		forever #50 clock_in = ~clock_in;
	end
	initial begin
		ulp_clk = 1'h0;
		forever #350 ulp_clk = ~ulp_clk;
	end
	initial begin
		int_clk = 1'h0;
		forever #230 int_clk = int_run ? ~int_clk : 1'h0; // Stands low while stopped.
	end

	// Reference edges seen while the crystal runs, and the hang limit.
	always @(posedge ulp_clk) ulp_edges <= ext_run ? ulp_edges + 1 : 0;
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus transfer; read data and error are kept in rd and err.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'h1;
		do @(posedge clock_in); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic settle();
		repeat (4) @(posedge clock_in);
	endtask

	// Polls the status register until the given ready bit is up.
	task automatic wait_ready(input int b);
		rd = 32'h0;
		for (int i = 0; i < 400 && rd[b] !== 1'h1; i++) apb(1'h0, STAT, 32'h0);
	endtask

	task automatic print_verdict();
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{rst_in, psel, penable, pwrite, paddr, pwdata, standby} = {1'h1, 44'h0};
		{ext_req, int_req, failures, num_checks, cycles, ulp_edges} = '0;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'h0;
		apb(1'h0, EXT, 32'h0);
		check(rd, 32'h0000_0080);
		apb(1'h0, INT, 32'h0);
		check(rd, 32'h003f_0080);
		check(32'(cal), 32'h3f);
		apb(1'h0, 8'h30, 32'h0);
		check({rd[31:1], err}, 32'h1);
		apb(1'h1, `LFO_OFF_MP_CTRL, 32'h6);
		settle();
		check(32'({mp_run, mp_pad, mp_oe}), 32'h7);
		apb(1'h1, `LFO_OFF_MP_CTRL, 32'h2);
		settle();
		check(32'({mp_run, mp_pad, mp_oe}), 32'h4);
		apb(1'h1, IEN, 32'h6);
		apb(1'h1, EXT, 32'h0000_072e);
		settle();
		check(32'({ext_run, ext_pad, ext_oe, ext_aa, ext_oen}), 32'h1f);
		wait_ready(1);
		check(32'(ulp_edges >= (131072 >> SHIFT)), 32'h1);
		check(32'(pad_edges >= 3), 32'h1);
		settle();
		check(32'(irq), 32'h1);
		apb(1'h1, IEN, 32'h0);
		settle();
		check(32'(irq), 32'h0);
		apb(1'h1, `LFO_OFF_IRQ_CLEAR, 32'h2);
		apb(1'h0, `LFO_OFF_IRQ_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'h1, IEN, 32'h6);
		apb(1'h1, EXT, 32'h82);
		settle();
		apb(1'h0, STAT, 32'h0);
		check({rd[1], 31'(ext_run)}, 32'h0);
		ext_req <= 4'h4;
		settle();
		check(32'(ext_run), 32'h1);
		standby <= 1'h1;
		settle();
		check(32'(ext_run), 32'h0);
		apb(1'h1, EXT, 32'hc2);
		settle();
		check(32'(ext_run), 32'h1);
		ext_req <= 4'h0;
		settle();
		check(32'(ext_run), 32'h0);
		apb(1'h1, EXT, 32'h42);
		settle();
		check(32'(ext_run), 32'h1);
		standby <= 1'h0;
		apb(1'h1, EXT, 32'h1002);
		apb(1'h1, EXT, 32'h0);
		apb(1'h0, EXT, 32'h0);
		check(rd, 32'h0000_1002);
		apb(1'h1, `LFO_OFF_IRQ_CLEAR, 32'h6);
		apb(1'h1, INT, 32'h0015_0006);
		settle();
		check(32'({int_run, int_oen, cal}), 32'h195);
		wait_ready(2);
		check(rd & 32'h4, 32'h4);
		settle();
		check(32'(irq), 32'h1);
		apb(1'h1, INT, 32'h0015_0082);
		int_req <= 4'h1;
		standby <= 1'h1;
		settle();
		check(32'(int_run), 32'h0);
		standby <= 1'h0;
		settle();
		check(32'(int_run), 32'h1);
		apb(1'h1, INT, 32'h0015_1002);
		apb(1'h1, INT, 32'h0);
		apb(1'h0, INT, 32'h0);
		check(rd, 32'h0015_1002);
		rst_in <= 1'h1;
		repeat (3) @(posedge clock_in);
		rst_in <= 1'h0;
		apb(1'h0, EXT, 32'h0);
		check(rd, 32'h0000_0080);
		apb(1'h1, EXT, 32'h2);
		wait_ready(1);
		check(rd & 32'h2, 32'h2);
		check(32'(pad_edges >= 3), 32'h1);
		print_verdict();
	end
endmodule
